/* logic/ctp_capture.sv */
// Trigger-position and acquisition-stop control of an on-chip logic analyzer.
// Assumes samples and trigger actions synchronous to ref_clk_i, and an
// Avalon-MM master on the register port.
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "ctp_consts.svh"

module ctp_capture (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Sample stream from probed logic
	input wire logic [7:0] smp_data_i,
	input wire logic smp_valid_i,
	output logic smp_ready_o,
	// Stop actions from the trigger flow
	input wire logic buf_stop_i,
	input wire logic seg_end_i,
	input wire logic post_fill_vld_i,
	input wire logic [6:0] post_fill_i,
	// Boot arming and status
	input wire logic boot_arm_en_i,
	output logic armed_o,
	output logic acq_done_o
);
	// ****************************************
	// Functions
	// ****************************************

	// Samples kept before the trigger for a preset
	function automatic logic [6:0] pre_len(input logic [1:0] pos, input logic [6:0] n);
		int prod;
		prod = 0;
		unique case (pos)
			ctp_pkg::CTP_POS_EARLY: prod = int'(n) * `CTP_PCT_EARLY;
			ctp_pkg::CTP_POS_LATE: prod = int'(n) * `CTP_PCT_LATE;
			default: prod = int'(n) * (`CTP_PCT_FULL / 2);
		endcase
		return 7'(prod / `CTP_PCT_FULL);
	endfunction

	// Valid-bit mask of one segment
	function automatic logic [63:0] seg_mask(input logic [1:0] seg);
		return 64'h0000_0000_0000_ffff << {seg, 4'h0};
	endfunction

	// ****************************************
	// Declarations
	// ****************************************

	ctp_pkg::ctp_state_e state_ff, nxt_state;
	logic [5:0] wptr_ff, nxt_wptr;
	logic [1:0] seg_ff, nxt_seg;
	logic [6:0] cnt_ff, nxt_cnt;
	logic last_ff, nxt_last;
	logic [1:0] pos_ff, nxt_pos;
	logic smode_ff, nxt_smode;
	logic [63:0] valid_ff, nxt_valid;
	logic [6:0] tidx_ff [4];
	logic [6:0] nxt_tidx [4];
	logic [6:0] inval_ff [4];
	logic [6:0] nxt_inval [4];
	logic boot_pend_ff, nxt_boot_pend;
	logic [7:0] mem_ff [64];

	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rt_pos_ff, nxt_rt_pos;
	logic [1:0] pu_pos_ff, nxt_pu_pos;
	logic segcfg_ff, nxt_segcfg;
	logic [1:0] sel_ff, nxt_sel;
	logic [5:0] rdaddr_ff, nxt_rdaddr;

	logic [7:0] fifo_data;
	logic fifo_valid;
	logic acquiring;
	logic wr_en;
	logic wr_ctrl;
	logic boot_arm;
	logic arm;
	logic sw_stop;
	logic [6:0] depth;
	logic [6:0] post;
	logic [1:0] nseg;
	logic stop_pre;
	logic stop_post;

	// ****************************************
	// Sample buffering
	// ****************************************

	// Back-pressure reaches the probed logic while the block is not acquiring
	ctp_fifo #(
		.WIDTH(`CTP_SMP_W),
		.DEPTH(`CTP_FIFO_D)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.in_data_i(smp_data_i),
		.in_valid_i(smp_valid_i),
		.in_ready_o(smp_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(acquiring)
	);

	assign acquiring = (state_ff == ctp_pkg::CTP_ST_PRE) || (state_ff == ctp_pkg::CTP_ST_POST);
	assign wr_en = fifo_valid && acquiring;
	assign armed_o = acquiring;
	assign acq_done_o = (state_ff == ctp_pkg::CTP_ST_DONE);

	// ****************************************
	// Acquisition control
	// ****************************************

	assign wr_ctrl = avs_write_i && ack_ff && avs_byteenable_i[0] && (avs_address_i == `CTP_OFS_CTRL);
	assign boot_arm = boot_pend_ff && boot_arm_en_i;
	assign arm = boot_arm || (wr_ctrl && avs_writedata_i[`CTP_CTRL_RUN]);
	assign sw_stop = wr_ctrl && avs_writedata_i[`CTP_CTRL_STOP];
	assign depth = smode_ff ? `CTP_SEG_DEPTH : `CTP_BUF_DEPTH;
	assign nseg = seg_ff + 2'h1;
	// Without segments, end-segment is ignored before the trigger and after it too, as the tail always has last_ff set
	assign stop_pre = buf_stop_i || (seg_end_i && smode_ff);
	assign stop_post = !last_ff && (buf_stop_i || seg_end_i);

	// Tail count: explicit one wins, else the preset split
	always_comb begin
		if (post_fill_vld_i) begin
			post = (post_fill_i > depth) ? depth : post_fill_i;
		end else begin
			post = depth - pre_len(pos_ff, depth);
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_wptr = wptr_ff;
		nxt_seg = seg_ff;
		nxt_cnt = cnt_ff;
		nxt_last = last_ff;
		nxt_pos = pos_ff;
		nxt_smode = smode_ff;
		nxt_valid = valid_ff;
		nxt_tidx = tidx_ff;
		nxt_inval = inval_ff;
		nxt_boot_pend = 1'b0;
		if (wr_en) begin
			nxt_valid[wptr_ff] = 1'b1;
			nxt_wptr = smode_ff ? {seg_ff, wptr_ff[3:0] + 4'h1} : wptr_ff + 6'h01;
		end
		if (arm) begin
			nxt_state = ctp_pkg::CTP_ST_PRE;
			nxt_pos = boot_arm ? pu_pos_ff : rt_pos_ff;
			nxt_smode = segcfg_ff;
			nxt_wptr = 6'h00;
			nxt_seg = 2'h0;
			nxt_cnt = 7'h00;
			nxt_last = 1'b0;
			nxt_valid = 64'h0;
			for (int i = 0; i < 4; i++) begin
				nxt_tidx[i] = 7'h00;
				nxt_inval[i] = 7'h00;
			end
		end else if (sw_stop && acquiring) begin
			nxt_state = ctp_pkg::CTP_ST_DONE;
		end else begin
			unique case (state_ff)
				ctp_pkg::CTP_ST_PRE: begin
					if (stop_pre) begin
						nxt_tidx[seg_ff] = depth - post;
						nxt_last = buf_stop_i;
						nxt_cnt = post;
						if (post != 7'h00) begin
							nxt_state = ctp_pkg::CTP_ST_POST;
						end else if (buf_stop_i) begin
							nxt_state = ctp_pkg::CTP_ST_DONE;
						end else begin
							nxt_seg = nseg;
							nxt_wptr = {nseg, 4'h0};
							nxt_valid = nxt_valid & ~seg_mask(nseg);
						end
					end
				end
				ctp_pkg::CTP_ST_POST: begin
					if (stop_post) begin
						// Unfilled tail is dropped and its length recorded
						nxt_inval[seg_ff] = cnt_ff - {6'h00, wr_en};
						if (buf_stop_i) begin
							nxt_state = ctp_pkg::CTP_ST_DONE;
						end else begin
							nxt_seg = nseg;
							nxt_wptr = {nseg, 4'h0};
							nxt_valid = nxt_valid & ~seg_mask(nseg);
							nxt_tidx[nseg] = depth - post;
							nxt_cnt = post;
							nxt_state = (post != 7'h00) ? ctp_pkg::CTP_ST_POST : ctp_pkg::CTP_ST_PRE;
						end
					end else if (wr_en) begin
						nxt_cnt = cnt_ff - 7'h01;
						if (cnt_ff == 7'h01) begin
							if (last_ff) begin
								nxt_state = ctp_pkg::CTP_ST_DONE;
							end else begin
								nxt_state = ctp_pkg::CTP_ST_PRE;
								nxt_seg = nseg;
								nxt_wptr = {nseg, 4'h0};
								nxt_valid = nxt_valid & ~seg_mask(nseg);
							end
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= ctp_pkg::CTP_ST_IDLE;
			wptr_ff <= 6'h00;
			seg_ff <= 2'h0;
			cnt_ff <= 7'h00;
			last_ff <= 1'b0;
			pos_ff <= `CTP_PU_POS_RST;
			smode_ff <= `CTP_SEG_RST;
			valid_ff <= 64'h0;
			boot_pend_ff <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				tidx_ff[i] <= 7'h00;
				inval_ff[i] <= 7'h00;
			end
		end else begin
			state_ff <= nxt_state;
			wptr_ff <= nxt_wptr;
			seg_ff <= nxt_seg;
			cnt_ff <= nxt_cnt;
			last_ff <= nxt_last;
			pos_ff <= nxt_pos;
			smode_ff <= nxt_smode;
			valid_ff <= nxt_valid;
			boot_pend_ff <= nxt_boot_pend;
			tidx_ff <= nxt_tidx;
			inval_ff <= nxt_inval;
		end
	end

	// Sample storage, no reset needed: valid bits guard it
	always_ff @(posedge ref_clk_i) begin
		if (wr_en) begin
			mem_ff[wptr_ff] <= fifo_data;
		end
	end

	// ****************************************
	// Register slave
	// ****************************************

	// One wait cycle on every access; write lands on the released edge
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
	assign avs_readdata_o = rdata_ff;

	always_comb begin
		nxt_ack = (avs_read_i || avs_write_i) && !ack_ff;
		nxt_rt_pos = rt_pos_ff;
		nxt_pu_pos = pu_pos_ff;
		nxt_segcfg = segcfg_ff;
		nxt_sel = sel_ff;
		nxt_rdaddr = rdaddr_ff;
		nxt_rdata = rdata_ff;
		if (avs_write_i && ack_ff && avs_byteenable_i[0]) begin
			unique case (avs_address_i)
				`CTP_OFS_CTRL: begin
					nxt_segcfg = avs_writedata_i[`CTP_CTRL_SEG];
					nxt_rt_pos = avs_writedata_i[`CTP_CTRL_RT_POS +: 2];
					nxt_pu_pos = avs_writedata_i[`CTP_CTRL_PU_POS +: 2];
				end
				`CTP_OFS_SEG_SEL: nxt_sel = avs_writedata_i[1:0];
				`CTP_OFS_RD_ADDR: nxt_rdaddr = avs_writedata_i[5:0];
				default: begin
				end
			endcase
		end
		if (avs_read_i && !ack_ff) begin
			unique case (avs_address_i)
				`CTP_OFS_CTRL: nxt_rdata = {25'h0, 1'b0, pu_pos_ff, rt_pos_ff, segcfg_ff, 1'b0};
				`CTP_OFS_STATUS: nxt_rdata = {16'h0, 1'b0, cnt_ff, 2'h0, seg_ff, last_ff, smode_ff, state_ff};
				`CTP_OFS_SEG_SEL: nxt_rdata = {30'h0, sel_ff};
				`CTP_OFS_SEG_INFO: nxt_rdata = {17'h0, inval_ff[sel_ff], 1'b0, tidx_ff[sel_ff]};
				`CTP_OFS_RD_ADDR: nxt_rdata = {26'h0, rdaddr_ff};
				`CTP_OFS_RD_DATA: nxt_rdata = {23'h0, valid_ff[rdaddr_ff], mem_ff[rdaddr_ff]};
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rt_pos_ff <= `CTP_RT_POS_RST;
			pu_pos_ff <= `CTP_PU_POS_RST;
			segcfg_ff <= `CTP_SEG_RST;
			sel_ff <= 2'h0;
			rdaddr_ff <= 6'h00;
		end else begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			rt_pos_ff <= nxt_rt_pos;
			pu_pos_ff <= nxt_pu_pos;
			segcfg_ff <= nxt_segcfg;
			sel_ff <= nxt_sel;
			rdaddr_ff <= nxt_rdaddr;
		end
	end
endmodule

/* pkg/ctp_consts.svh */
// Offsets, field positions, reset values and depths of the capture block.
// Assumes inclusion by bare name from the design files.
`ifndef CTP_CONSTS_SVH
`define CTP_CONSTS_SVH

// Register byte offsets
`define CTP_OFS_CTRL 5'h00
`define CTP_OFS_STATUS 5'h04
`define CTP_OFS_SEG_SEL 5'h08
`define CTP_OFS_SEG_INFO 5'h0c
`define CTP_OFS_RD_ADDR 5'h10
`define CTP_OFS_RD_DATA 5'h14

// Control field positions
`define CTP_CTRL_RUN 0
`define CTP_CTRL_SEG 1
`define CTP_CTRL_RT_POS 2
`define CTP_CTRL_PU_POS 4
`define CTP_CTRL_STOP 6

// Reset values
`define CTP_RT_POS_RST 2'h1
`define CTP_PU_POS_RST 2'h1
`define CTP_SEG_RST 1'h0

// Depths, widths and ratios
`define CTP_BUF_DEPTH 7'h40
`define CTP_SEG_DEPTH 7'h10
`define CTP_PCT_EARLY 12
`define CTP_PCT_LATE 88
`define CTP_PCT_FULL 100
`define CTP_SMP_W 8
`define CTP_FIFO_D 8

`endif

/* pkg/ctp_pkg.sv */
// Types shared by the capture block.
// Assumes nothing of its surroundings.
package ctp_pkg;

	typedef enum logic [1:0] {
		CTP_ST_IDLE = 2'b00,
		CTP_ST_PRE = 2'b01,
		CTP_ST_POST = 2'b10,
		CTP_ST_DONE = 2'b11
	} ctp_state_e;

	typedef enum logic [1:0] {
		CTP_POS_EARLY = 2'b00,
		CTP_POS_MID = 2'b01,
		CTP_POS_LATE = 2'b10
	} ctp_pos_e;

endpackage

/* logic/ctp_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module ctp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Filling side
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	// Draining side
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0] wptr_ff;
	logic [AW:0] rptr_ff;
	logic [AW:0] nxt_wptr;
	logic [AW:0] nxt_rptr;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
	assign empty = (wptr_ff == rptr_ff);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_ff[rptr_ff[AW-1:0]];
	assign push = in_valid_i && !full;
	assign pop = out_ready_i && !empty;

	always_comb begin
		nxt_wptr = push ? wptr_ff + 1'b1 : wptr_ff;
		nxt_rptr = pop ? rptr_ff + 1'b1 : rptr_ff;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
		end
	end

	// Storage needs no reset; empty guards the output
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_ff[wptr_ff[AW-1:0]] <= in_data_i;
		end
	end
endmodule

/* test/ctp_capture_props.sv */
// Port checker of the capture block, bound onto its top module.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module ctp_capture_props (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Watched ports
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic smp_ready_o,
	input wire logic boot_arm_en_i,
	input wire logic armed_o,
	input wire logic acq_done_o
);
	// ********
	// Properties
	// ********
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	sequence req_s;
		avs_read_i || avs_write_i;
	endsequence
	sequence full_armed_s;
		armed_o && !smp_ready_o;
	endsequence
	chk_one_wait: assert property (req_s ##0 avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus access waited more than one cycle");
	chk_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("waitrequest high without access");
	chk_wait_first: assert property ($rose(avs_read_i) || $rose(avs_write_i) |-> avs_waitrequest_o)
		else $error("new access completed without a wait");
	chk_boot_arm: assert property (!$past(arst_n_i) && boot_arm_en_i |=> armed_o)
		else $error("boot arming missing after reset");
	chk_no_boot: assert property (!$past(arst_n_i) && !boot_arm_en_i |=> !armed_o && !acq_done_o)
		else $error("armed after reset without boot arming");
	chk_state_excl: assert property (!(armed_o && acq_done_o))
		else $error("armed and done together");
	chk_done_holds: assert property (acq_done_o && !avs_write_i |=> acq_done_o)
		else $error("done left without a write");
	chk_idle_full: assert property (!armed_o && !smp_ready_o && !avs_write_i |=> !smp_ready_o)
		else $error("samples drained while not armed");
	chk_armed_drain: assert property (full_armed_s |=> smp_ready_o)
		else $error("no sample written while armed");
endmodule

bind ctp_capture ctp_capture_props chk_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.smp_ready_o(smp_ready_o), .boot_arm_en_i(boot_arm_en_i), .armed_o(armed_o), .acq_done_o(acq_done_o));

/* test/ctp_probe_model.sv */
// Behavioural model of the probed logic sending samples.
// Assumes valid/ready taken at the rising edge.
`timescale 1ns/10ps
module ctp_probe_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Control from the bench
	input wire logic run_i,
	input wire logic slow_i,
	// Sample stream
	output logic [7:0] smp_data_o,
	output logic smp_valid_o,
	input wire logic smp_ready_i
);
	// ********
	// Source
	// ********
	logic [7:0] cnt_ff;
	logic tick_ff;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= 8'h00;
			tick_ff <= 1'b0;
		end else begin
			if (!smp_valid_o || smp_ready_i) begin
				tick_ff <= ~tick_ff;
			end
			if (smp_valid_o && smp_ready_i) begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end
	assign smp_valid_o = run_i && (!slow_i || tick_ff);
	// Idle data inverted so a stale value never passes
	assign smp_data_o = smp_valid_o ? cnt_ff : ~cnt_ff;
endmodule

/* test/test_ctp_capture.sv */
// Self-checking bench of the capture block.
// Assumes the checker and probe model compiled before it.
`timescale 1ns/10ps
`include "ctp_consts.svh"
module test_ctp_capture;
	// ********
	// Stimulus and tasks
	// ********
	typedef struct {logic seg; logic [1:0] pos; logic fv; logic [6:0] fc; logic [6:0] post;} ctp_row_s;
	ctp_row_s rows [9] = '{'{1'h0, 2'h0, 1'h0, 7'h00, 7'h39}, '{1'h0, 2'h1, 1'h0, 7'h00, 7'h20},
		'{1'h0, 2'h2, 1'h0, 7'h00, 7'h08}, '{1'h0, 2'h1, 1'h1, 7'h0a, 7'h0a},
		'{1'h0, 2'h1, 1'h1, 7'h64, 7'h40}, '{1'h1, 2'h0, 1'h0, 7'h00, 7'h0f},
		'{1'h1, 2'h1, 1'h0, 7'h00, 7'h08}, '{1'h1, 2'h2, 1'h0, 7'h00, 7'h02},
		'{1'h1, 2'h1, 1'h1, 7'h05, 7'h05}};
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic rd = 1'b0, wr = 1'b0, bs = 1'b0, se = 1'b0, fv = 1'b0, boot = 1'b0, run = 1'b0, slow = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wdat = 32'h0, rdat, rdq;
	logic [3:0] be = 4'hf;
	logic [6:0] fc = 7'h00, dep;
	logic [7:0] sd;
	logic [1:0] seg;
	logic wt, sv, sr, armed, done;
	ctp_row_s r;
	int n_mismatch = 0, check_count = 0, n;
	always #50 ref_clk_i = ~ref_clk_i;
	ctp_capture dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdq),
		.avs_waitrequest_o(wt), .smp_data_i(sd), .smp_valid_i(sv), .smp_ready_o(sr), .buf_stop_i(bs),
		.seg_end_i(se), .post_fill_vld_i(fv), .post_fill_i(fc), .boot_arm_en_i(boot), .armed_o(armed),
		.acq_done_o(done));
	ctp_probe_model probe_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .run_i(run), .slow_i(slow),
		.smp_data_o(sd), .smp_valid_o(sv), .smp_ready_i(sr));
	task automatic stop_test;
		if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic limit(input int k, input int m);
		if (k >= m) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic clk(input int k);
		repeat (k) @(posedge ref_clk_i);
	endtask
	// Waitrequest and read data taken at the rising edge, before the slave updates
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (wt !== 1'b0 && k < 50);
		limit(k, 50);
		rdat = rdq;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic stop(input logic s, input logic v, input logic [6:0] c);
		bs <= !s;
		se <= s;
		fv <= v;
		fc <= c;
		@(posedge ref_clk_i);
		bs <= 1'b0;
		se <= 1'b0;
		fv <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	// ********
	// Sequence
	// ********
	initial begin
		clk(5);
		arst_n_i <= 1'b1;
		run <= 1'b1;
		clk(1);
		bus(0, `CTP_OFS_STATUS, 32'h0);
		chk(rdat[1:0], 2'h0);
		be <= 4'he;
		bus(1, `CTP_OFS_CTRL, 32'h08);
		be <= 4'hf;
		bus(1, 5'h1c, 32'hff);
		bus(0, `CTP_OFS_CTRL, 32'h0);
		chk(rdat, 32'h14);
		bus(0, 5'h18, 32'h0);
		chk(rdat, 32'h0);
		foreach (rows[i]) begin
			r = rows[i];
			dep = r.seg ? `CTP_SEG_DEPTH : `CTP_BUF_DEPTH;
			slow <= r.seg;
			// Arming takes the position held before its own write
			bus(1, `CTP_OFS_CTRL, {26'h0, 2'h1, r.pos, r.seg, 1'b0});
			bus(1, `CTP_OFS_CTRL, {26'h0, 2'h1, r.pos, r.seg, 1'b1});
			clk(20);
			run <= 1'b0;
			clk(12);
			stop(r.seg, r.fv, r.fc);
			bus(0, `CTP_OFS_STATUS, 32'h0);
			chk(rdat[14:8], r.post);
			chk(rdat[1:0], 2'h2);
			seg = rdat[5:4];
			run <= 1'b1;
			n = 0;
			do begin
				bus(0, `CTP_OFS_STATUS, 32'h0);
				n++;
			end while (rdat[1:0] != 2'h3 && rdat[5:4] == seg && n < 200);
			limit(n, 200);
			chk(done, !r.seg);
			bus(1, `CTP_OFS_SEG_SEL, {30'h0, seg});
			bus(0, `CTP_OFS_SEG_INFO, 32'h0);
			chk(rdat[6:0], dep - r.post);
		end
		// Segment tail cut short by a buffer stop
		bus(1, `CTP_OFS_CTRL, 32'h17);
		clk(20);
		run <= 1'b0;
		clk(12);
		stop(1, 0, 7'h00);
		bus(0, `CTP_OFS_STATUS, 32'h0);
		seg = rdat[5:4];
		stop(0, 0, 7'h00);
		chk(done, 1'b1);
		bus(1, `CTP_OFS_SEG_SEL, {30'h0, seg});
		bus(0, `CTP_OFS_SEG_INFO, 32'h0);
		chk(rdat[14:8], 7'h08);
		bus(1, `CTP_OFS_RD_ADDR, 32'h30);
		bus(0, `CTP_OFS_RD_ADDR, 32'h0);
		chk(rdat, 32'h30);
		bus(0, `CTP_OFS_RD_DATA, 32'h0);
		chk(rdat[8], 1'b0);
		bus(1, `CTP_OFS_RD_ADDR, 32'h00);
		bus(0, `CTP_OFS_RD_DATA, 32'h0);
		chk(rdat[8], 1'b1);
		// Boot arming keeps its own position
		arst_n_i <= 1'b0;
		boot <= 1'b1;
		clk(5);
		arst_n_i <= 1'b1;
		clk(2);
		chk(armed, 1'b1);
		bus(1, `CTP_OFS_CTRL, 32'h18);
		stop(0, 0, 7'h00);
		bus(0, `CTP_OFS_STATUS, 32'h0);
		chk(rdat[14:8], 7'h20);
		bus(1, `CTP_OFS_CTRL, 32'h40);
		chk(done, 1'b1);
		stop_test();
	end
endmodule
